/* inc/scs_pkg.sv */
// package: constants, register map and types of the switchgear command supervisor
package scs_pkg;

	// ==========================================================
	// clock and time base
	localparam int unsigned CLK_HZ   = 25_000_000;                  // system clock rate
	localparam int unsigned TICK_US  = 1000;                        // timer tick period in us
	localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US; // cycles per tick

	// ==========================================================
	// supervision times, in milliseconds (one tick each)
	localparam int          TMR_W    = 16;                          // timer counter width
	localparam logic [15:0] SUPV_MS  = 16'h0064;                    // contradiction supervision
	localparam logic [15:0] SYNC_MS  = 16'h03e8;                    // synchronism wait
	localparam logic [15:0] MOVE_MS  = 16'h00c8;                    // breaker travel limit

	// ==========================================================
	// apb register map (byte addresses)
	localparam int          ADDR_W    = 8;
	localparam logic [7:0]  ADDR_CTRL = 8'h00;                      // rw: mode bits
	localparam logic [7:0]  ADDR_CMD  = 8'h04;                      // wo: command strobes
	localparam logic [7:0]  ADDR_STAT = 8'h08;                      // ro: position and state
	localparam logic [7:0]  ADDR_CNT  = 8'h0c;                      // ro: fault counters
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;              // ctrl after reset

	// field positions
	localparam int CTRL_ONE_CONTACT = 0;                            // one-contact position mode
	localparam int CMD_CLOSE        = 0;                            // close request
	localparam int CMD_OPEN         = 1;                            // open request
	localparam int CMD_SYNC         = 2;                            // close waits for sync
	localparam int CMD_CNT_CLR      = 3;                            // clear fault counters

	// ==========================================================
	// command outcome flag indices
	localparam int OC_OK        = 0;
	localparam int OC_DISTURBED = 1;
	localparam int OC_TRIP      = 2;
	localparam int OC_DIR       = 3;
	localparam int OC_CDO       = 4;
	localparam int OC_NOT_READY = 5;
	localparam int OC_INTERLOCK = 6;
	localparam int OC_SYNC_TO   = 7;
	localparam int OC_WITHDRAWN = 8;
	localparam int OC_N         = 9;

	localparam int LOCK_N = 3;                                      // interlock inputs per dir
	localparam int CNT_W  = 16;                                     // fault counter width

	typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_MOVE} scs_state_e;

endpackage : scs_pkg

/* inc/scs_tmr_if.sv */
// interface: control and status of one supervision timer
`timescale 1ns/100ps
interface scs_tmr_if;
	import scs_pkg::*;
	logic             run;     // timer counts while high, clears while low
	logic             tick;    // one-cycle time base enable
	logic [TMR_W-1:0] limit;   // expiry count in ticks
	logic             expired; // level, high once limit is reached
	modport owner (output run, output tick, output limit, input expired);
	modport timer (input run, input tick, input limit, output expired);
endinterface : scs_tmr_if

/* src/scs_timer.sv */
// module: tick-counting supervision timer
`timescale 1ns/100ps
module scs_timer
	import scs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// control
	scs_tmr_if.timer t
);
	logic [TMR_W-1:0] cnt_q; // elapsed ticks

	// ==========================================================
	// counter: clears whenever run drops, so a restart needs one low cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_q <= '0;
		end else if (!t.run) begin
			cnt_q <= '0;
		end else if (t.tick && cnt_q != t.limit) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign t.expired = t.run && (cnt_q == t.limit);
endmodule : scs_timer

/* src/scs_top.sv */
// module: switchgear position evaluation and command execution supervision
// Operation
// - close interlock indication when any close lock
// - open interlock indication when any open lock
// - contradiction starts timer, disturbed on expiry
// - one-contact mode: no unknown or disturbed
// - aggregate moving flag while position unknown
// - aggregate faulted flag while position disturbed
// - success flag when requested position reached
// - disturbed-result flag when command ends disturbed
// - refuse command while trip pending, flag it
// - direction error for redundant open or close
// - flag close arriving during pending open
// - refuse command when breaker not ready
// - refuse command blocked by field interlock
// - abandon sync close when sync timer expires
// - refuse command while breaker withdrawn
// - suppress trip output while trip blocked
// - counter reset clears both fault counters
`timescale 1ns/100ps
module scs_top
	import scs_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYC // cycles per 1 ms tick
)(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// breaker pins
	input  wire logic              closed_contact_in,
	input  wire logic              open_contact_in,
	input  wire logic              ready_in,
	input  wire logic              withdrawn_in,
	input  wire logic              in_sync_in,
	input  wire logic [LOCK_N-1:0] close_lock_input,
	input  wire logic [LOCK_N-1:0] open_lock_input,
	// protection pins
	input  wire logic              prot_trip_in,
	input  wire logic              trip_block_input,
	// commands out
	output logic                   close_cmd_out,
	output logic                   open_cmd_out,
	output logic                   trip_cmd_out,
	// position indications
	output logic                   position_closed,
	output logic                   position_open,
	output logic                   position_not_closed,
	output logic                   position_unknown,
	output logic                   position_disturbed,
	output logic                   any_gear_moving,
	output logic                   any_gear_faulted,
	output logic                   breaker_withdrawn,
	output logic                   close_interlock_active,
	output logic                   open_interlock_active,
	// command outcome pulses
	output logic                   cmd_ok,
	output logic                   cmd_fail_disturbed,
	output logic                   cmd_fail_trip_pending,
	output logic                   cmd_direction_error,
	output logic                   close_during_open,
	output logic                   cmd_fail_not_ready,
	output logic                   cmd_fail_interlock,
	output logic                   cmd_fail_sync_timeout,
	output logic                   cmd_fail_withdrawn
);
	localparam int PIN_N = 7 + 2 * LOCK_N;

	// ==========================================================
	// pin synchronisers: two flops before any logic looks
	logic [PIN_N-1:0] meta_q;  // first stage, read only by sync_q
	logic [PIN_N-1:0] sync_q;  // second stage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= {prot_trip_in, trip_block_input, in_sync_in, withdrawn_in, ready_in,
			           open_contact_in, closed_contact_in, open_lock_input, close_lock_input};
			sync_q <= meta_q;
		end
	end
	wire [LOCK_N-1:0] cl_lock_s   = sync_q[LOCK_N-1:0];
	wire [LOCK_N-1:0] op_lock_s   = sync_q[2*LOCK_N-1:LOCK_N];
	wire              closed_s    = sync_q[2*LOCK_N];
	wire              open_s      = sync_q[2*LOCK_N+1];
	wire              ready_s     = sync_q[2*LOCK_N+2];
	wire              withdrawn_s = sync_q[2*LOCK_N+3];
	wire              in_sync_s   = sync_q[2*LOCK_N+4];
	wire              trip_blk_s  = sync_q[2*LOCK_N+5];
	wire              trip_s      = sync_q[2*LOCK_N+6];

	// ==========================================================
	// apb decode, zero wait states
	logic [31:0]      ctrl_q;      // mode register
	logic [31:0]      rdata_q;     // read data captured in setup phase
	logic [CNT_W-1:0] fault_cnt_q; // trips seen
	logic [CNT_W-1:0] grid_cnt_q;  // trips that hit a closed breaker
	logic [OC_N-1:0]  outcome_q;   // outcome pulses
	logic [OC_N-1:0]  last_oc_q;   // latest outcome, held for software
	scs_state_e       state_q, state_d;
	wire hit_ctrl  = paddr == ADDR_CTRL;
	wire hit_cmd   = paddr == ADDR_CMD;
	wire hit_stat  = paddr == ADDR_STAT;
	wire hit_cnt   = paddr == ADDR_CNT;
	wire mapped    = hit_ctrl | hit_cmd | hit_stat | hit_cnt;
	wire acc       = psel & penable;
	wire wr_ctrl   = acc & pwrite & hit_ctrl;
	wire wr_cmd    = acc & pwrite & hit_cmd;
	wire req_close = wr_cmd & pwdata[CMD_CLOSE];
	wire req_open  = wr_cmd & pwdata[CMD_OPEN];
	wire req_sync  = pwdata[CMD_SYNC];
	wire cnt_clr   = wr_cmd & pwdata[CMD_CNT_CLR];
	wire one_mode  = ctrl_q[CTRL_ONE_CONTACT];
	wire [31:0] stat_w = {11'h000, last_oc_q, 2'h0, state_q, open_interlock_active,
	                      close_interlock_active, breaker_withdrawn, any_gear_faulted,
	                      position_disturbed, position_unknown, position_open,
	                      position_closed};
	wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
	                     hit_stat ? stat_w :
	                     hit_cnt  ? {grid_cnt_q, fault_cnt_q} : 32'h0000_0000;
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped; // unmapped address answers with an error
	assign prdata  = rdata_q;

	// registers: ctrl written at the access edge, read data sampled in setup
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_q  <= CTRL_RST;
			rdata_q <= 32'h0000_0000;
		end else begin
			if (wr_ctrl) ctrl_q <= {31'h0000_0000, pwdata[CTRL_ONE_CONTACT]};
			if (psel && !penable) rdata_q <= rd_mux;
		end
	end

	// ==========================================================
	// 1 ms tick divider and three timers
	logic [$clog2(TICK_CYCLES)-1:0] div_q; // tick divider
	wire tick = div_q == '0;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) div_q <= '0;
		else div_q <= tick ? ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1) : div_q - 1'b1;
	end
	scs_tmr_if supv_t ();
	scs_tmr_if sync_t ();
	scs_tmr_if move_t ();
	scs_timer u_supv (.clk(clk), .reset(reset), .t(supv_t.timer));
	scs_timer u_sync (.clk(clk), .reset(reset), .t(sync_t.timer));
	scs_timer u_move (.clk(clk), .reset(reset), .t(move_t.timer));

	// ==========================================================
	// position evaluation
	wire contra = closed_s & open_s & ~one_mode;
	assign supv_t.run   = contra;
	assign supv_t.tick  = tick;
	assign supv_t.limit = SUPV_MS;
	// one-contact mode trusts the closed contact alone
	wire pos_c_w = one_mode ? closed_s : closed_s & ~open_s;
	wire pos_o_w = one_mode ? ~closed_s : open_s & ~closed_s;
	wire pos_u_w = ~one_mode & ~closed_s & ~open_s;
	wire pos_d_w = contra & supv_t.expired;

	// indications registered so each of these outputs comes from a flop
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			position_closed        <= 1'b0;
			position_open          <= 1'b0;
			position_not_closed    <= 1'b1;
			position_unknown       <= 1'b0;
			position_disturbed     <= 1'b0;
			any_gear_moving        <= 1'b0;
			any_gear_faulted       <= 1'b0;
			breaker_withdrawn      <= 1'b0;
			close_interlock_active <= 1'b0;
			open_interlock_active  <= 1'b0;
			trip_cmd_out           <= 1'b0;
		end else begin
			position_closed        <= pos_c_w;
			position_open          <= pos_o_w;
			position_not_closed    <= ~pos_c_w;
			position_unknown       <= pos_u_w;
			position_disturbed     <= pos_d_w;
			any_gear_moving        <= pos_u_w;
			any_gear_faulted       <= pos_d_w;
			breaker_withdrawn      <= withdrawn_s;
			close_interlock_active <= |cl_lock_s;
			open_interlock_active  <= |op_lock_s;
			trip_cmd_out           <= trip_s & ~trip_blk_s;
		end
	end

	// ==========================================================
	// command execution supervision
	logic dir_close_q;  // direction of the running command
	logic dir_close_d;
	logic [OC_N-1:0] oc_d;
	wire any_req  = req_close | req_open;
	wire want_cl  = ~req_open;                                      // open wins a clash
	wire lock_hit = want_cl ? |cl_lock_s : |op_lock_s;
	wire at_goal  = dir_close_q ? pos_c_w : pos_o_w;
	assign sync_t.run   = state_q == ST_SYNC;
	assign sync_t.tick  = tick;
	assign sync_t.limit = SYNC_MS;
	assign move_t.run   = state_q == ST_MOVE;
	assign move_t.tick  = tick;
	assign move_t.limit = MOVE_MS;

	// checks in fixed priority; each command accepted in ST_IDLE yields one final outcome, plus a close_during_open pulse per close written while an open runs
	always_comb begin
		state_d     = state_q;
		dir_close_d = dir_close_q;
		oc_d        = '0;
		unique case (state_q)
			ST_IDLE: begin
				if (any_req) begin
					if (withdrawn_s) oc_d[OC_WITHDRAWN] = 1'b1;
					else if (trip_s) oc_d[OC_TRIP] = 1'b1;
					else if (!ready_s) oc_d[OC_NOT_READY] = 1'b1;
					else if (lock_hit) oc_d[OC_INTERLOCK] = 1'b1;
					else if (want_cl ? pos_c_w : pos_o_w) oc_d[OC_DIR] = 1'b1;
					else begin
						dir_close_d = want_cl;
						state_d     = (want_cl && req_sync) ? ST_SYNC : ST_MOVE;
					end
				end
			end
			ST_SYNC: begin
				if (in_sync_s) state_d = ST_MOVE;
				else if (sync_t.expired) begin
					oc_d[OC_SYNC_TO] = 1'b1;
					state_d          = ST_IDLE;
				end
			end
			ST_MOVE: begin
				if (req_close && !dir_close_q) oc_d[OC_CDO] = 1'b1;
				else if (at_goal) begin
					oc_d[OC_OK] = 1'b1;
					state_d     = ST_IDLE;
				end else if (pos_d_w || move_t.expired) begin
					// a breaker stuck short of its goal also counts as disturbed
					oc_d[OC_DISTURBED] = 1'b1;
					state_d            = ST_IDLE;
				end
			end
		endcase
	end

	// state, outcome pulses and commands to the breaker
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q     <= ST_IDLE;
			dir_close_q <= 1'b0;
			outcome_q   <= '0;
			last_oc_q   <= '0;
		end else begin
			state_q     <= state_d;
			dir_close_q <= dir_close_d;
			outcome_q   <= oc_d;
			if (|oc_d) last_oc_q <= oc_d;
		end
	end
	assign close_cmd_out = (state_q == ST_MOVE) & dir_close_q;
	assign open_cmd_out  = (state_q == ST_MOVE) & ~dir_close_q;
	assign cmd_ok                = outcome_q[OC_OK];
	assign cmd_fail_disturbed    = outcome_q[OC_DISTURBED];
	assign cmd_fail_trip_pending = outcome_q[OC_TRIP];
	assign cmd_direction_error   = outcome_q[OC_DIR];
	assign close_during_open     = outcome_q[OC_CDO];
	assign cmd_fail_not_ready    = outcome_q[OC_NOT_READY];
	assign cmd_fail_interlock    = outcome_q[OC_INTERLOCK];
	assign cmd_fail_sync_timeout = outcome_q[OC_SYNC_TO];
	assign cmd_fail_withdrawn    = outcome_q[OC_WITHDRAWN];

	// ==========================================================
	// fault counters; the clear beats a simultaneous trip edge
	logic trip_d1_q; // previous trip level for edge detection
	wire  trip_rise = trip_s & ~trip_d1_q;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			trip_d1_q   <= 1'b0;
			fault_cnt_q <= '0;
			grid_cnt_q  <= '0;
		end else begin
			trip_d1_q <= trip_s;
			if (cnt_clr) begin
				fault_cnt_q <= '0;
				grid_cnt_q  <= '0;
			end else if (trip_rise) begin
				fault_cnt_q <= fault_cnt_q + 1'b1;
				if (pos_c_w) grid_cnt_q <= grid_cnt_q + 1'b1;
			end
		end
	end

	// ==========================================================
	// assertions
	property p_il_close;
		@(posedge clk) disable iff (reset) close_interlock_active == $past(|cl_lock_s);
	endproperty
	a_il_close: assert property (p_il_close) else $error("close interlock wrong");
	property p_il_open;
		@(posedge clk) disable iff (reset) open_interlock_active == $past(|op_lock_s);
	endproperty
	a_il_open: assert property (p_il_open) else $error("open interlock wrong");
	property p_disturb;
		@(posedge clk) disable iff (reset) $rose(position_disturbed) |-> $past(contra, 2);
	endproperty
	a_disturb: assert property (p_disturb) else $error("disturbed without contradiction");
	property p_one_mode;
		@(posedge clk) disable iff (reset)
			one_mode && $past(one_mode) |-> !position_unknown && !position_disturbed;
	endproperty
	a_one_mode: assert property (p_one_mode) else $error("one-contact mode shows fault");
	property p_moving;
		@(posedge clk) disable iff (reset) any_gear_moving == position_unknown;
	endproperty
	a_moving: assert property (p_moving) else $error("moving flag mismatch");
	property p_faulted;
		@(posedge clk) disable iff (reset) any_gear_faulted == position_disturbed;
	endproperty
	a_faulted: assert property (p_faulted) else $error("faulted flag mismatch");
	property p_ok;
		@(posedge clk) disable iff (reset) cmd_ok |-> $past(state_q == ST_MOVE && at_goal);
	endproperty
	a_ok: assert property (p_ok) else $error("success without goal");
	property p_trip_ref;
		@(posedge clk) disable iff (reset)
			state_q == ST_IDLE && any_req && trip_s && !withdrawn_s
			|=> cmd_fail_trip_pending && state_q == ST_IDLE;
	endproperty
	a_trip_ref: assert property (p_trip_ref) else $error("command ran under trip");
	property p_blk;
		@(posedge clk) disable iff (reset) $past(trip_blk_s) |-> !trip_cmd_out;
	endproperty
	a_blk: assert property (p_blk) else $error("trip passed while blocked");
	property p_clr;
		@(posedge clk) disable iff (reset) cnt_clr |=> fault_cnt_q == '0 && grid_cnt_q == '0;
	endproperty
	a_clr: assert property (p_clr) else $error("counters not cleared");
	property p_onehot;
		// a close refused mid-open may be followed at once by the open's own outcome
		@(posedge clk) disable iff (reset)
			$onehot0(outcome_q) and (|outcome_q && !close_during_open |=> ~|outcome_q);
	endproperty
	a_onehot: assert property (p_onehot) else $error("outcome not a single pulse");
	c_ok:   cover property (@(posedge clk) disable iff (reset) cmd_ok);
	c_sync: cover property (@(posedge clk) disable iff (reset) cmd_fail_sync_timeout);
	c_cdo:  cover property (@(posedge clk) disable iff (reset) close_during_open);
endmodule : scs_top

/* sim/scs_brk_model.sv */
// partner model: breaker check-back contacts and synchronism source
`timescale 1ns/100ps
module scs_brk_model #(
	parameter int TRAVEL = 20 // cycles of travel between end positions
)(
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// commands from the relay
	input  wire logic close_cmd,
	input  wire logic open_cmd,
	// misbehaviour chosen by the bench
	input  wire logic stuck,
	input  wire logic fault,
	input  wire logic sync_ok,
	// contacts back to the relay
	output logic      closed_contact_in,
	output logic      open_contact_in,
	output logic      in_sync_in
);
	logic pos_q; // high while closed
	int   cnt;   // travel progress, zero at rest
	// ==========================================
	// mechanism: moves only when sent away from where it stands
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			pos_q <= 1'b0;
			cnt   <= 0;
		end else if (!stuck && (close_cmd ? !pos_q : open_cmd && pos_q)) begin
			cnt <= (cnt == TRAVEL) ? 0 : cnt + 1;
			if (cnt == TRAVEL) begin
				pos_q <= !pos_q;
			end
		end else begin
			cnt <= 0; // a dropped command leaves it at rest
		end
	end
	// both contacts open in mid-travel, both made on a fault
	assign closed_contact_in = fault | (pos_q & (cnt == 0));
	assign open_contact_in   = fault | (!pos_q & (cnt == 0));
	assign in_sync_in        = sync_ok;
endmodule : scs_brk_model

/* sim/tb_top.sv */
// testbench: self-checking bench of the switchgear command supervisor
`timescale 1ns/100ps
module tb_top;
	import scs_pkg::*;
	localparam int TK = 4; // short tick keeps timer runs brief
	// ==========================================
	// signals
	logic        clk = 1'b0, reset = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, r;
	wire  [31:0] prdata;
	wire         pready, pslverr;
	logic        ready_in = 1'b1, withdrawn_in = 1'b0, prot_trip_in = 1'b0;
	logic        trip_block_input = 1'b0, sync_ok = 1'b0, stuck = 1'b0, fault = 1'b0;
	logic [2:0]  close_lock_input = 3'h0, open_lock_input = 3'h0;
	wire         closed_contact_in, open_contact_in, in_sync_in;
	wire         ccmd, ocmd, tcmd, pc, po, pnc, pu, pd, mv, fl, bw, cil, oil;
	wire  [8:0]  oc; // outcome pulses by index
	logic        mv_seen;
	int          miscompares = 0, n_compared = 0, ref_closed = 0, ntrip = 0, seed;
	always #20 clk = ~clk;
	// ==========================================
	// design and breaker
	scs_top #(.TICK_CYCLES(TK)) i_dut (.clk, .reset, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .closed_contact_in, .open_contact_in, .ready_in,
		.withdrawn_in, .in_sync_in, .close_lock_input, .open_lock_input, .prot_trip_in,
		.trip_block_input, .close_cmd_out(ccmd), .open_cmd_out(ocmd), .trip_cmd_out(tcmd),
		.position_closed(pc), .position_open(po), .position_not_closed(pnc),
		.position_unknown(pu), .position_disturbed(pd), .any_gear_moving(mv),
		.any_gear_faulted(fl), .breaker_withdrawn(bw), .close_interlock_active(cil),
		.open_interlock_active(oil), .cmd_ok(oc[OC_OK]), .cmd_fail_disturbed(oc[OC_DISTURBED]),
		.cmd_fail_trip_pending(oc[OC_TRIP]), .cmd_direction_error(oc[OC_DIR]),
		.close_during_open(oc[OC_CDO]), .cmd_fail_not_ready(oc[OC_NOT_READY]),
		.cmd_fail_interlock(oc[OC_INTERLOCK]), .cmd_fail_sync_timeout(oc[OC_SYNC_TO]),
		.cmd_fail_withdrawn(oc[OC_WITHDRAWN]));
	scs_brk_model i_brk (.clk, .reset, .close_cmd(ccmd), .open_cmd(ocmd), .stuck, .fault,
		.sync_ok, .closed_contact_in, .open_contact_in, .in_sync_in);
	// ==========================================
	// reference model and helpers
	function automatic logic [8:0] oh(input int k);
		return 9'h001 << k;
	endfunction : oh
	// refusal causes in priority order, then direction, then success
	function automatic logic [8:0] exp_oc(input int cls);
		if (withdrawn_in) return oh(OC_WITHDRAWN);
		if (prot_trip_in) return oh(OC_TRIP);
		if (!ready_in) return oh(OC_NOT_READY);
		if (|(cls ? close_lock_input : open_lock_input)) return oh(OC_INTERLOCK);
		if (cls == ref_closed) return oh(OC_DIR);
		return oh(OC_OK);
	endfunction : exp_oc
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : print_verdict
	// one apb transfer, request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// pin conditions: c0 withdrawn, c1 trip, c2 not ready, c3 trip block
	task automatic pins(input logic [3:0] c, input logic [2:0] cl, input logic [2:0] ol);
		@(posedge clk);
		if (c[1] && !prot_trip_in) ntrip++;
		withdrawn_in     <= c[0];
		prot_trip_in     <= c[1];
		ready_in         <= !c[2];
		trip_block_input <= c[3];
		close_lock_input <= cl;
		open_lock_input  <= ol;
		repeat (5) @(negedge clk); // two sync flops plus the output register
	endtask : pins
	// wait, bounded, for one outcome pulse; it must be alone and last one cycle
	task automatic wait_oc(input logic [8:0] exp, input int lim);
		int n;
		n = 0;
		while (oc === 9'h000 && n < lim) begin
			@(negedge clk);
			mv_seen |= mv;
			n++;
		end
		check(oc, exp);
		@(negedge clk);
		check(oc, 9'h000);
	endtask : wait_oc
	task automatic do_cmd(input int cls);
		logic [8:0] e;
		e = exp_oc(cls);
		apb(1'b1, ADDR_CMD, cls ? 32'h1 : 32'h2);
		wait_oc(e, 900);
		if (e === oh(OC_OK)) ref_closed = cls;
		check({pc, po}, ref_closed ? 2'h2 : 2'h1);
	endtask : do_cmd
	// ==========================================
	// watchdog against a hang
	initial begin
		repeat (30000) @(posedge clk);
		miscompares++;
		print_verdict();
	end
	// ==========================================
	// scenarios
	initial begin
		seed = 32'h5d5d9528;
		mv_seen = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b0, ADDR_CTRL, 32'h0);
		check(r, CTRL_RST);
		apb(1'b1, 8'h10, 32'hffffffff);
		check(err, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		check({err, r[30:0]}, 32'h80000000);
		check({pc, po, pnc}, 3'h3);
		repeat (4) begin
			pins(4'h0, 3'($random(seed)), 3'($random(seed)));
			check(cil, |close_lock_input);
			check(oil, |open_lock_input);
		end
		pins(4'h0, 3'h0, 3'h0);
		do_cmd(1);
		check(mv_seen, 1'b1);
		do_cmd(1);
		// each refusal cause alone on an open request
		for (int k = 0; k < 4; k++) begin
			pins((k < 3) ? 4'(1 << k) : 4'h0, 3'h0, (k == 3) ? 3'h4 : 3'h0);
			check(bw, (k == 0));
			do_cmd(0);
		end
		pins(4'h2, 3'h0, 3'h0);
		check(tcmd, 1'b1);
		pins(4'ha, 3'h0, 3'h0);
		check(tcmd, 1'b0);
		// random mixes of causes check the priority
		repeat (8) begin
			pins(4'($random(seed) & $random(seed) & 7), 3'($random(seed) & $random(seed)),
				3'($random(seed) & $random(seed)));
			do_cmd($random(seed) & 1);
		end
		pins(4'h0, 3'h0, 3'h0);
		if (ref_closed == 0) do_cmd(1);
		// close arriving while the open is still travelling
		apb(1'b1, ADDR_CMD, 32'h2);
		apb(1'b1, ADDR_CMD, 32'h1);
		wait_oc(oh(OC_CDO), 50);
		check({ccmd, ocmd}, 2'h1);
		wait_oc(oh(OC_OK), 900);
		ref_closed = 0;
		apb(1'b1, ADDR_CMD, 32'h5);
		wait_oc(oh(OC_SYNC_TO), 4200);
		apb(1'b0, ADDR_STAT, 32'h0);
		check(r, 32'h0000_0002 | {11'h000, oh(OC_SYNC_TO), 12'h000});
		@(posedge clk);
		sync_ok <= 1'b1;
		apb(1'b1, ADDR_CMD, 32'h5);
		wait_oc(oh(OC_OK), 900);
		@(posedge clk);
		sync_ok <= 1'b0;
		stuck   <= 1'b1;
		apb(1'b1, ADDR_CMD, 32'h2);
		wait_oc(oh(OC_DISTURBED), 900);
		@(posedge clk);
		stuck <= 1'b0;
		fault <= 1'b1;
		repeat (380) @(negedge clk);
		check(pd, 1'b0);
		repeat (40) @(negedge clk);
		check({pd, fl}, 2'h3);
		@(posedge clk);
		fault <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h1);
		@(posedge clk);
		fault <= 1'b1;
		repeat (420) @(negedge clk);
		check({pd, pu, pc}, 3'h1);
		@(posedge clk);
		fault <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h0);
		apb(1'b0, ADDR_CNT, 32'h0);
		check(r[15:0], ntrip);
		apb(1'b1, ADDR_CMD, 32'h8);
		apb(1'b0, ADDR_CNT, 32'h0);
		check(r, 32'h0);
		print_verdict();
	end
endmodule : tb_top
